// >>> rtl/dma_channel_trigger_irq_config.sv
// What this block does
// - Abort selector 8 bits picks interrupt number that aborts transfer and sets abort flag
// - Start selector 8 bits picks interrupt number that starts a transfer
// - Writing one to force command starts a transfer at once; reads zero
// - Writing one to soft abort command aborts the transfer; reads zero
// - Pattern abort enabled: match aborts and clears channel enable; else ignored
// - Start-on-interrupt enabled: matching interrupt starts one cell; else ignored
// - Abort-on-interrupt enabled: matching interrupt aborts; else ignored
// - Eight enables in bits 23:16 pair with eight flags in low byte
// - Source done flag sets when source pointer equals source size
// - Source half flag sets when source pointer reaches half of source size
// - Destination done flag sets when destination pointer equals destination size
// - Destination half flag sets when destination pointer reaches half its size
// - Block done flag sets after larger size moved, or on pattern abort
// - Cell done flag sets each time cell size bytes have moved
// - Abort flag sets when abort interrupt is detected and transfer aborted
// - Address error flag sets when source or destination address is invalid
// - Source size N means N bytes; zero means 65,536 bytes
// - Destination size N means N bytes; zero means 65,536 bytes
// - Events-while-disabled set: events registered while disabled; else ignored
// - Without auto re-enable, block completion clears channel enable
//
// Local design decisions: register access over APB and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module dma_channel_trigger_irq_config
    import dma_chan_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    // System interrupt events
    input wire logic irq_valid,
    input wire logic [7:0] irq_num,
    // Transfer engine
    input wire logic byte_moved,
    input wire logic pattern_match,
    input wire logic addr_error,
    input wire logic [15:0] cell_size,
    output logic cell_active,
    output logic start_pulse,
    output logic abort_pulse,
    output logic channel_enable,
    output logic [31:0] src_start_addr,
    output logic [31:0] dst_start_addr,
    // Channel interrupt
    output logic irq_req
);

    ////////////////////////////////////////////////////////////////////////
    // Registers

    logic [7:0] abort_irq_select;
    logic [7:0] start_irq_select;
    logic pattern_abort_enable;
    logic start_on_irq_enable;
    logic abort_on_irq_enable;
    logic [7:0] irq_enables;
    logic [7:0] irq_flags;
    logic [15:0] src_size;
    logic [15:0] dst_size;
    logic events_while_disabled;
    logic auto_reenable;
    logic start_pending;
    chan_state_t state;

    progress_if src_prg ();
    progress_if dst_prg ();
    progress_if blk_prg ();
    progress_if cell_prg ();

    ////////////////////////////////////////////////////////////////////////
    // APB decode

    logic access;
    logic wr_fire;
    logic rd_fire;
    logic addr_ok;
    logic [31:0] read_word;

    assign access = psel && penable && !pready;
    assign wr_fire = psel && penable && pready && pwrite;
    assign rd_fire = access && !pwrite;

    function automatic logic wr_hit(input logic fire, input logic [7:0] addr, input logic [7:0] ofs);
        wr_hit = fire && (addr == ofs);
    endfunction : wr_hit

    always_comb begin
        addr_ok = 1'b1;
        read_word = 32'h00000000;
        unique case (paddr)
            OFS_EVENT_CTRL: begin
                read_word[ABORT_SEL_LSB +: 8] = abort_irq_select;
                read_word[START_SEL_LSB +: 8] = start_irq_select;
                read_word[PATTERN_EN_BIT] = pattern_abort_enable;
                read_word[START_EN_BIT] = start_on_irq_enable;
                read_word[ABORT_EN_BIT] = abort_on_irq_enable;
            end
            OFS_INT_CTRL: begin
                read_word[IE_LSB +: 8] = irq_enables;
                read_word[7:0] = irq_flags;
            end
            OFS_SRC_ADDR: read_word = src_start_addr;
            OFS_DST_ADDR: read_word = dst_start_addr;
            OFS_SRC_SIZE: read_word[15:0] = src_size;
            OFS_DST_SIZE: read_word[15:0] = dst_size;
            OFS_CHAN_CTRL: begin
                read_word[BUSY_BIT] = (state == ST_CELL) || channel_enable;
                read_word[ENABLE_BIT] = channel_enable;
                read_word[EVT_DIS_BIT] = events_while_disabled;
                read_word[AUTO_REEN_BIT] = auto_reenable;
            end
            OFS_SRC_PTR: read_word[15:0] = src_prg.pointer[15:0];
            OFS_DST_PTR: read_word[15:0] = dst_prg.pointer[15:0];
            OFS_CELL_PTR: read_word[15:0] = cell_prg.pointer[15:0];
            default: addr_ok = 1'b0;
        endcase
    end

    // One wait state: the answer is registered in the first access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= access;
            pslverr <= access && !addr_ok;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
        end else if (rd_fire) begin
            prdata <= read_word;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Configuration writes

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            abort_irq_select <= ABORT_SEL_RESET;
            start_irq_select <= START_SEL_RESET;
            pattern_abort_enable <= 1'b0;
            start_on_irq_enable <= 1'b0;
            abort_on_irq_enable <= 1'b0;
        end else if (wr_hit(wr_fire, paddr, OFS_EVENT_CTRL)) begin
            abort_irq_select <= pwdata[ABORT_SEL_LSB +: 8];
            start_irq_select <= pwdata[START_SEL_LSB +: 8];
            pattern_abort_enable <= pwdata[PATTERN_EN_BIT];
            start_on_irq_enable <= pwdata[START_EN_BIT];
            abort_on_irq_enable <= pwdata[ABORT_EN_BIT];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            src_start_addr <= 32'h00000000;
            dst_start_addr <= 32'h00000000;
            src_size <= 16'h0000;
            dst_size <= 16'h0000;
        end else begin
            if (wr_hit(wr_fire, paddr, OFS_SRC_ADDR)) begin
                src_start_addr <= pwdata;
            end
            if (wr_hit(wr_fire, paddr, OFS_DST_ADDR)) begin
                dst_start_addr <= pwdata;
            end
            if (wr_hit(wr_fire, paddr, OFS_SRC_SIZE)) begin
                src_size <= pwdata[15:0];
            end
            if (wr_hit(wr_fire, paddr, OFS_DST_SIZE)) begin
                dst_size <= pwdata[15:0];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_enables <= 8'h00;
            events_while_disabled <= 1'b0;
            auto_reenable <= 1'b0;
        end else begin
            if (wr_hit(wr_fire, paddr, OFS_INT_CTRL)) begin
                irq_enables <= pwdata[IE_LSB +: 8];
            end
            if (wr_hit(wr_fire, paddr, OFS_CHAN_CTRL)) begin
                events_while_disabled <= pwdata[EVT_DIS_BIT];
                auto_reenable <= pwdata[AUTO_REEN_BIT];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Event detection

    logic allowed;
    logic start_hit;
    logic abort_hit;
    logic force_cmd;
    logic soft_abort;
    logic pattern_abort;
    logic any_abort;
    logic block_end;

    assign allowed = channel_enable || events_while_disabled;

    irq_match u_start_match (
        .irq_valid(irq_valid),
        .irq_num(irq_num),
        .select(start_irq_select),
        .enable(start_on_irq_enable),
        .allowed(allowed),
        .hit(start_hit)
    );

    irq_match u_abort_match (
        .irq_valid(irq_valid),
        .irq_num(irq_num),
        .select(abort_irq_select),
        .enable(abort_on_irq_enable),
        .allowed(allowed),
        .hit(abort_hit)
    );

    assign force_cmd = wr_hit(wr_fire, paddr, OFS_EVENT_CTRL) && pwdata[FORCE_BIT];
    assign soft_abort = wr_hit(wr_fire, paddr, OFS_EVENT_CTRL) && pwdata[SOFT_ABORT_BIT];
    assign pattern_abort = pattern_match && pattern_abort_enable;
    assign any_abort = soft_abort || abort_hit || pattern_abort;
    assign block_end = blk_prg.done;

    ////////////////////////////////////////////////////////////////////////
    // Progress counters

    logic moving;
    logic [16:0] src_bytes;
    logic [16:0] dst_bytes;

    // Bytes after a cell's end are not counted
    assign moving = byte_moved && (state == ST_CELL) && !any_abort && !cell_prg.done && !block_end;
    assign src_bytes = size_bytes(src_size);
    assign dst_bytes = size_bytes(dst_size);

    assign src_prg.step = moving;
    assign src_prg.clear = any_abort || block_end;
    assign src_prg.limit = src_bytes;
    assign dst_prg.step = moving;
    assign dst_prg.clear = any_abort || block_end;
    assign dst_prg.limit = dst_bytes;
    assign blk_prg.step = moving;
    assign blk_prg.clear = any_abort;
    assign blk_prg.limit = (src_bytes > dst_bytes) ? src_bytes : dst_bytes;
    assign cell_prg.step = moving;
    assign cell_prg.clear = any_abort || block_end;
    assign cell_prg.limit = size_bytes(cell_size);

    progress_counter u_src_cnt (
        .pclk(pclk),
        .presetn(presetn),
        .prg(src_prg.counter)
    );

    progress_counter u_dst_cnt (
        .pclk(pclk),
        .presetn(presetn),
        .prg(dst_prg.counter)
    );

    progress_counter u_blk_cnt (
        .pclk(pclk),
        .presetn(presetn),
        .prg(blk_prg.counter)
    );

    progress_counter u_cell_cnt (
        .pclk(pclk),
        .presetn(presetn),
        .prg(cell_prg.counter)
    );

    ////////////////////////////////////////////////////////////////////////
    // Channel state

    logic launch;

    // A start seen while busy or disabled waits here until it can run
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            start_pending <= 1'b0;
        end else if (any_abort) begin
            start_pending <= 1'b0;
        end else if (start_hit || (force_cmd && !launch)) begin
            start_pending <= 1'b1;
        end else if (launch) begin
            start_pending <= 1'b0;
        end
    end

    assign launch = (state == ST_IDLE) && (force_cmd || (channel_enable && start_pending));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= ST_IDLE;
        end else begin
            unique case (state)
                ST_IDLE: begin
                    if (!any_abort && launch) begin
                        state <= ST_CELL;
                    end
                end
                ST_CELL: begin
                    if (any_abort || cell_prg.done || block_end) begin
                        state <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            channel_enable <= 1'b0;
        end else if (pattern_abort) begin
            channel_enable <= 1'b0;
        end else if (block_end && !auto_reenable) begin
            channel_enable <= 1'b0;
        end else if (force_cmd) begin
            channel_enable <= 1'b1;
        end else if (wr_hit(wr_fire, paddr, OFS_CHAN_CTRL)) begin
            channel_enable <= pwdata[ENABLE_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Interrupt flags

    logic [7:0] flag_set;

    always_comb begin
        flag_set = 8'h00;
        flag_set[FLAG_SRC_DONE] = src_prg.done;
        flag_set[FLAG_SRC_HALF] = src_prg.half;
        flag_set[FLAG_DST_DONE] = dst_prg.done;
        flag_set[FLAG_DST_HALF] = dst_prg.half;
        flag_set[FLAG_BLOCK_DONE] = block_end || pattern_abort;
        flag_set[FLAG_CELL_DONE] = cell_prg.done;
        flag_set[FLAG_XFER_ABORT] = abort_hit;
        flag_set[FLAG_ADDR_ERROR] = addr_error;
    end

    // Hardware set wins over a software write in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_flags <= 8'h00;
        end else if (wr_hit(wr_fire, paddr, OFS_INT_CTRL)) begin
            irq_flags <= pwdata[7:0] | flag_set;
        end else begin
            irq_flags <= irq_flags | flag_set;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_req <= 1'b0;
        end else begin
            irq_req <= |(irq_flags & irq_enables);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Engine strobes

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cell_active <= 1'b0;
            start_pulse <= 1'b0;
            abort_pulse <= 1'b0;
        end else begin
            cell_active <= (state == ST_IDLE) ? (launch && !any_abort)
                : !(any_abort || cell_prg.done || block_end);
            start_pulse <= (state == ST_IDLE) && launch && !any_abort;
            abort_pulse <= any_abort;
        end
    end

endmodule : dma_channel_trigger_irq_config
`default_nettype wire

// >>> rtl/dma_chan_pkg.sv
package dma_chan_pkg;

    // Register byte offsets
    localparam logic [7:0] OFS_EVENT_CTRL = 8'h00;
    localparam logic [7:0] OFS_INT_CTRL = 8'h04;
    localparam logic [7:0] OFS_SRC_ADDR = 8'h08;
    localparam logic [7:0] OFS_DST_ADDR = 8'h0C;
    localparam logic [7:0] OFS_SRC_SIZE = 8'h10;
    localparam logic [7:0] OFS_DST_SIZE = 8'h14;
    localparam logic [7:0] OFS_CHAN_CTRL = 8'h18;
    localparam logic [7:0] OFS_SRC_PTR = 8'h1C;
    localparam logic [7:0] OFS_DST_PTR = 8'h20;
    localparam logic [7:0] OFS_CELL_PTR = 8'h24;

    // Event control fields
    localparam int ABORT_SEL_LSB = 16;
    localparam int START_SEL_LSB = 8;
    localparam int FORCE_BIT = 7;
    localparam int SOFT_ABORT_BIT = 6;
    localparam int PATTERN_EN_BIT = 5;
    localparam int START_EN_BIT = 4;
    localparam int ABORT_EN_BIT = 3;

    // Interrupt control fields
    localparam int IE_LSB = 16;
    localparam int FLAG_SRC_DONE = 7;
    localparam int FLAG_SRC_HALF = 6;
    localparam int FLAG_DST_DONE = 5;
    localparam int FLAG_DST_HALF = 4;
    localparam int FLAG_BLOCK_DONE = 3;
    localparam int FLAG_CELL_DONE = 2;
    localparam int FLAG_XFER_ABORT = 1;
    localparam int FLAG_ADDR_ERROR = 0;

    // Channel control fields
    localparam int BUSY_BIT = 15;
    localparam int ENABLE_BIT = 7;
    localparam int EVT_DIS_BIT = 6;
    localparam int AUTO_REEN_BIT = 4;

    // Reset values
    localparam logic [7:0] ABORT_SEL_RESET = 8'hFF;
    localparam logic [7:0] START_SEL_RESET = 8'hFF;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_CELL = 2'b10
    } chan_state_t;

    // A size field of zero stands for 65,536 bytes
    function automatic logic [16:0] size_bytes(input logic [15:0] field);
        size_bytes = (field == 16'h0000) ? 17'h10000 : {1'b0, field};
    endfunction : size_bytes

endpackage : dma_chan_pkg

// >>> rtl/progress_if.sv
`timescale 1ns/1ps
`default_nettype none
interface progress_if;
    logic step;
    logic clear;
    logic [16:0] limit;
    logic [16:0] pointer;
    logic half;
    logic done;

    modport counter (input step, clear, limit, output pointer, half, done);
    modport owner (output step, clear, limit, input pointer, half, done);
endinterface : progress_if
`default_nettype wire

// >>> rtl/irq_match.sv
`timescale 1ns/1ps
`default_nettype none
module irq_match (
    // Interrupt event
    input wire logic irq_valid,
    input wire logic [7:0] irq_num,
    // Selection
    input wire logic [7:0] select,
    input wire logic enable,
    input wire logic allowed,
    // Result
    output logic hit
);
    assign hit = irq_valid && enable && allowed && (irq_num == select);
endmodule : irq_match
`default_nettype wire

// >>> rtl/progress_counter.sv
`timescale 1ns/1ps
`default_nettype none
module progress_counter (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Counter side
    progress_if.counter prg
);
    logic [16:0] next_pointer;

    assign next_pointer = prg.pointer + 17'h00001;

    // Wraps to zero on reaching the limit; half and done are one-cycle pulses
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prg.pointer <= 17'h00000;
            prg.half <= 1'b0;
            prg.done <= 1'b0;
        end else begin
            prg.half <= 1'b0;
            prg.done <= 1'b0;
            if (prg.clear) begin
                prg.pointer <= 17'h00000;
            end else if (prg.step) begin
                prg.half <= (next_pointer == (prg.limit >> 1));
                if (next_pointer == prg.limit) begin
                    prg.pointer <= 17'h00000;
                    prg.done <= 1'b1;
                end else begin
                    prg.pointer <= next_pointer;
                end
            end
        end
    end
endmodule : progress_counter
`default_nettype wire

// >>> tb/engine_model.sv
`timescale 1ns/1ps
`default_nettype none
module engine_model (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Engine side
    input wire logic cell_active,
    input wire logic slow,
    output logic byte_moved
);
    // One byte a cycle, or on random cycles when stalling
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            byte_moved <= 1'b0;
        end else begin
            byte_moved <= cell_active && (!slow || $urandom_range(1) == 1);
        end
    end
endmodule : engine_model
`default_nettype wire

// >>> tb/dma_channel_props.sv
`timescale 1ns/1ps
`default_nettype none
module dma_channel_props
    import dma_chan_pkg::*;
(
    // Clock, reset and bus
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    // Events and engine
    input wire logic irq_valid,
    input wire logic [7:0] irq_num,
    input wire logic pattern_match,
    input wire logic cell_active,
    input wire logic start_pulse,
    input wire logic abort_pulse,
    input wire logic channel_enable,
    input wire logic irq_req
);
    logic wr_ok;
    logic [31:0] evt;
    logic [7:0] ie;
    assign wr_ok = psel && penable && pready && pwrite;
    // Shadow of the event and enable settings
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            evt <= 32'h00FFFF00;
        end else if (wr_ok && paddr == OFS_EVENT_CTRL) begin
            evt <= pwdata;
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ie <= 8'h00;
        end else if (wr_ok && paddr == OFS_INT_CTRL) begin
            ie <= pwdata[23:16];
        end
    end
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    sequence s_evt_wr;
        wr_ok && paddr == OFS_EVENT_CTRL;
    endsequence
    sequence s_abort_irq;
        irq_valid && irq_num == evt[23:16] && evt[3] && channel_enable && cell_active;
    endsequence
    sequence s_start_irq;
        irq_valid && irq_num == evt[15:8] && irq_num != evt[23:16] && evt[4] && channel_enable && !cell_active;
    endsequence
    AST_ABORT_IRQ: assert property (s_abort_irq |-> ##[1:2] abort_pulse)
        else $error("abort interrupt did not abort");
    AST_ABORT_IDLE: assert property (abort_pulse |-> !cell_active)
        else $error("channel active after abort");
    AST_START_IRQ: assert property (s_start_irq ##0 !wr_ok |-> ##[1:2] start_pulse && cell_active)
        else $error("start interrupt did not start a cell");
    AST_START_PAIR: assert property (start_pulse |-> cell_active)
        else $error("start pulse without active cell");
    AST_FORCE: assert property (s_evt_wr ##0 (pwdata[7] && !pwdata[6]) |=> cell_active && channel_enable)
        else $error("forced start missing");
    AST_SOFT_ABORT: assert property (s_evt_wr ##0 (pwdata[6] && cell_active) |-> ##[1:2] abort_pulse)
        else $error("software abort missing");
    AST_PATTERN: assert property (pattern_match && evt[5] && cell_active |-> ##[1:2] !channel_enable)
        else $error("pattern match left channel enabled");
    AST_IE_ZERO: assert property (ie == 8'h00 |=> !irq_req)
        else $error("request with all enables clear");
endmodule : dma_channel_props
bind dma_channel_trigger_irq_config dma_channel_props u_props (.*);
`default_nettype wire

// >>> tb/dma_channel_trigger_irq_config_bench.sv
`timescale 1ns/1ps
`default_nettype none
module dma_channel_trigger_irq_config_bench
    import dma_chan_pkg::*;
;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic irq_valid = 1'b0, pattern_match = 1'b0, addr_error = 1'b0, slow = 1'b0;
    logic [7:0] irq_num = 8'h00;
    logic [15:0] cell_size = 16'h0004;
    logic pready, pslverr, byte_moved, cell_active, start_pulse, abort_pulse, channel_enable, irq_req;
    logic [31:0] prdata, src_start_addr, dst_start_addr, q, d;
    logic [7:0] ssel, asel;
    int failures = 0;
    int tests_run = 0;

    dma_channel_trigger_irq_config DUT (.*);
    engine_model partner (.*);

    initial begin
        forever #20 pclk = ~pclk;
    end
    initial begin
        #800000;
        failures++;
        results();
    end
    ////////////////////////////////////////////////////////////////
    task automatic results;
        $display("checks %0d failures %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : results
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        tests_run++;
        if (s !== e) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] v);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= v;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        q = prdata;
        chk("pready", 32'h1, {31'h0, pready});
        chk("pslverr", {31'h0, a > 8'h24}, {31'h0, pslverr});
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, $urandom());
        chk($sformatf("reg %h", a), e, q);
    endtask : rd
    task automatic ev(input logic [7:0] b);
        apb(1'b1, OFS_EVENT_CTRL, {8'h00, asel, ssel, b});
    endtask : ev
    task automatic pulse_irq(input logic [7:0] n);
        irq_valid <= 1'b1;
        irq_num <= n;
        @(posedge pclk);
        irq_valid <= 1'b0;
        @(posedge pclk);
    endtask : pulse_irq
    task automatic wait_ca(input logic v);
        int n;
        n = 0;
        while (cell_active !== v && n < 300) begin
            @(posedge pclk);
            n++;
        end
        chk("cell_active", {31'h0, v}, {31'h0, cell_active});
    endtask : wait_ca
    // Model of the progress flags for equal source and destination sizes
    function automatic logic [7:0] prog(input int s, input int n);
        logic dn;
        logic hf;
        dn = n >= s;
        hf = n >= s / 2;
        prog = {dn, hf, dn, hf, dn, 3'b000};
    endfunction : prog
    ////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(34));
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(OFS_EVENT_CTRL, 32'h00FFFF00);
        rd(OFS_INT_CTRL, 32'h0);
        rd(8'h28, 32'h0);
        $display("test reset done");
        for (int i = 2; i < 6; i++) begin
            d = $urandom();
            apb(1'b1, 8'(i * 4), d);
            rd(8'(i * 4), (i < 4) ? d : {16'h0, d[15:0]});
            if (i < 4) chk("start_addr", d, (i == 2) ? src_start_addr : dst_start_addr);
        end
        d = $urandom() & 32'h00FF00FF;
        apb(1'b1, OFS_INT_CTRL, d);
        rd(OFS_INT_CTRL, d);
        chk("irq_req", {31'h0, |(d[23:16] & d[7:0])}, {31'h0, irq_req});
        apb(1'b1, OFS_INT_CTRL, 32'h0);
        // Ordinary peripheral sources only, never the forbidden ones
        ssel = 8'($urandom_range(0, 200));
        asel = ssel + 8'h01;
        d = $urandom() & 32'h00FFFF38;
        apb(1'b1, OFS_EVENT_CTRL, d);
        rd(OFS_EVENT_CTRL, d);
        $display("test registers done");
        apb(1'b1, OFS_SRC_SIZE, 32'h8);
        apb(1'b1, OFS_DST_SIZE, 32'h8);
        apb(1'b1, OFS_INT_CTRL, 32'h00040000);
        apb(1'b1, OFS_CHAN_CTRL, 32'h80);
        ev(8'h18);
        for (int k = 1; k <= 2; k++) begin
            pulse_irq(ssel);
            wait_ca(1'b1);
            wait_ca(1'b0);
            repeat (2) @(posedge pclk);
            rd(OFS_INT_CTRL, {8'h00, 8'h04, 8'h00, prog(8, 4 * k) | 8'h04});
            chk("irq_req", 32'h1, {31'h0, irq_req});
        end
        chk("channel_enable", 32'h0, {31'h0, channel_enable});
        apb(1'b1, OFS_INT_CTRL, 32'h0);
        pulse_irq(ssel);
        repeat (4) @(posedge pclk);
        chk("cell_active", 32'h0, {31'h0, cell_active});
        apb(1'b1, OFS_CHAN_CTRL, 32'h40);
        pulse_irq(ssel);
        apb(1'b1, OFS_CHAN_CTRL, 32'hC0);
        wait_ca(1'b1);
        wait_ca(1'b0);
        ev(8'h08);
        pulse_irq(ssel);
        repeat (4) @(posedge pclk);
        chk("cell_active", 32'h0, {31'h0, cell_active});
        $display("test start done");
        apb(1'b1, OFS_INT_CTRL, 32'h0);
        apb(1'b1, OFS_SRC_SIZE, 32'h0);
        apb(1'b1, OFS_DST_SIZE, 32'h0);
        cell_size <= 16'h0010;
        slow <= 1'b1;
        ev(8'h18);
        pulse_irq(ssel);
        wait_ca(1'b1);
        pulse_irq(asel);
        wait_ca(1'b0);
        rd(OFS_INT_CTRL, 32'h2);
        repeat (8) @(posedge pclk);
        chk("cell_active", 32'h0, {31'h0, cell_active});
        ev(8'h10);
        pulse_irq(ssel);
        wait_ca(1'b1);
        pulse_irq(asel);
        chk("cell_active", 32'h1, {31'h0, cell_active});
        ev(8'h50);
        wait_ca(1'b0);
        rd(OFS_EVENT_CTRL, {8'h00, asel, ssel, 8'h10});
        $display("test abort done");
        slow <= 1'b0;
        ev(8'h80);
        wait_ca(1'b1);
        chk("channel_enable", 32'h1, {31'h0, channel_enable});
        rd(OFS_EVENT_CTRL, {8'h00, asel, ssel, 8'h00});
        ev(8'h40);
        wait_ca(1'b0);
        apb(1'b1, OFS_INT_CTRL, 32'h0);
        ev(8'h30);
        pulse_irq(ssel);
        wait_ca(1'b1);
        pattern_match <= 1'b1;
        @(posedge pclk);
        pattern_match <= 1'b0;
        wait_ca(1'b0);
        repeat (2) @(posedge pclk);
        chk("channel_enable", 32'h0, {31'h0, channel_enable});
        rd(OFS_INT_CTRL, 32'h8);
        apb(1'b1, OFS_INT_CTRL, 32'h0);
        apb(1'b1, OFS_CHAN_CTRL, 32'h80);
        ev(8'h10);
        pulse_irq(ssel);
        pattern_match <= 1'b1;
        @(posedge pclk);
        pattern_match <= 1'b0;
        repeat (2) @(posedge pclk);
        chk("cell_active", 32'h1, {31'h0, cell_active});
        ev(8'h50);
        wait_ca(1'b0);
        addr_error <= 1'b1;
        @(posedge pclk);
        addr_error <= 1'b0;
        repeat (2) @(posedge pclk);
        rd(OFS_INT_CTRL, 32'h1);
        $display("test pattern and error done");
        results();
    end
endmodule : dma_channel_trigger_irq_config_bench
`default_nettype wire
